/* verilog/vpic_ctrl.sv */
// Vectored priority interrupt controller top with Avalon-MM register slave
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
module vpic_ctrl (
  input wire logic clock_i,                          // 250 MHz system clock
  input wire logic reset_i,                          // Synchronous reset, active high
  input wire vpic_pkg::vpic_avm_req_t avm_i,         // Avalon-MM request
  output vpic_pkg::vpic_avm_rsp_t avm_o,             // Avalon-MM answer
  input wire logic [vpic_pkg::NUM_USER-1:0] src_req_i, // Peripheral request pulses
  input wire logic [vpic_pkg::EXT_PINS-1:0] ext_pin_i, // External request pins
  input wire logic [vpic_pkg::TRAP_FLAGS-1:0] trap_event_i, // Trap cause pulses
  input wire logic trap_entry_i,                     // Core enters a trap handler
  input wire logic cpu_ack_i,                        // Core takes presented interrupt
  input wire logic cpu_ret_i,                        // Core returns from handler
  input wire logic [vpic_pkg::LVL_W-1:0] cpu_ret_level_i, // Level restored on return
  output vpic_pkg::vpic_cpu_req_t cpu_o              // Request to the core
);
  import vpic_pkg::*;

  // Register state
  logic [REG_W-1:0] ctrl_a_q;
  logic [REG_W-1:0] ctrl_b_q;
  logic [PRI_W-1:0] cpu_pri_q;
  logic cpu_top_q;
  logic [FLAG_BITS-1:0] flag_q;
  logic [FLAG_BITS-1:0] enable_q;
  logic [PRIO_BITS-1:0] prio_q;
  logic [DEPTH_W-1:0] depth_q;
  logic irq_q;
  logic [VEC_W-1:0] vec_q;
  logic [LVL_W-1:0] lvl_q;
  logic [23:0] addr_q;
  logic phase_q;
  logic [31:0] rdata_q;

  // Bus handshake: one wait state, then the request is taken
  wire bus_req = avm_i.read | avm_i.write;
  wire bus_acc = bus_req & phase_q;
  wire wr_acc = bus_acc & avm_i.write;
  wire [7:0] addr = avm_i.address;
  wire [15:0] wdata = avm_i.writedata[15:0];
  wire [15:0] be_mask = {{8{avm_i.byteenable[1]}}, {8{avm_i.byteenable[0]}}};

  // Register window decode
  wire [7:0] flag_rel = addr - OFS_FLAG0;
  wire [7:0] en_rel = addr - OFS_ENABLE0;
  wire [7:0] prio_rel = addr - OFS_PRIO0;
  wire in_flag = addr >= OFS_FLAG0 && flag_rel < 8'(FLAG_REGS * 4) && addr[1:0] == 2'b00;
  wire in_en = addr >= OFS_ENABLE0 && en_rel < 8'(FLAG_REGS * 4) && addr[1:0] == 2'b00;
  wire in_prio = addr >= OFS_PRIO0 && prio_rel < 8'(PRIO_REGS * 4) && addr[1:0] == 2'b00;
  wire [2:0] flag_idx = flag_rel[4:2];
  wire [2:0] en_idx = en_rel[4:2];
  wire [4:0] prio_idx = prio_rel[6:2];

  // Derived control
  wire nest_off = ctrl_a_q[CTRLA_NEST_BIT];
  wire alt_sel = ctrl_b_q[CTRLB_ALT_BIT];
  wire [LVL_W-1:0] cpu_level = {cpu_top_q, cpu_pri_q};

  // External pins become flag set pulses
  // Polarity comes from the low bits of control B; the edge lags the pin by about 4 cycles
  logic [EXT_PINS-1:0] ext_evt;

  vpic_pin_sync #(
    .W(EXT_PINS)
  ) u_pin_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .pin_i(ext_pin_i),
    .fall_sel_i(ctrl_b_q[EXT_PINS-1:0]),
    .edge_o(ext_evt)
  );

  // Hardware set sources, indexed by vector minus the first user vector
  logic [FLAG_BITS-1:0] set_vec;
  always_comb
  begin
    set_vec = '0;
    set_vec[NUM_USER-1:0] = src_req_i;
    set_vec[VEC_EXT0 - FIRST_USER_VEC] = src_req_i[VEC_EXT0 - FIRST_USER_VEC] | ext_evt[0];
    set_vec[VEC_EXT1 - FIRST_USER_VEC] = src_req_i[VEC_EXT1 - FIRST_USER_VEC] | ext_evt[1];
    set_vec[VEC_EXT2 - FIRST_USER_VEC] = src_req_i[VEC_EXT2 - FIRST_USER_VEC] | ext_evt[2];
  end

  // Per-word write masks for flag, enable and priority banks
  logic [FLAG_BITS-1:0] flag_wmask;
  logic [FLAG_BITS-1:0] en_wmask;
  logic [PRIO_BITS-1:0] prio_wmask;
  logic [FLAG_BITS-1:0] flag_wdata;
  logic [PRIO_BITS-1:0] prio_wdata;

  for (genvar i = 0; i < FLAG_REGS; i++)
  begin : g_flag_word
    assign flag_wmask[i*REG_W +: REG_W] = (wr_acc && in_flag && flag_idx == 3'(i)) ? be_mask : '0;
    assign en_wmask[i*REG_W +: REG_W] = (wr_acc && in_en && en_idx == 3'(i)) ? be_mask : '0;
    assign flag_wdata[i*REG_W +: REG_W] = wdata;
  end

  for (genvar k = 0; k < PRIO_REGS; k++)
  begin : g_prio_word
    assign prio_wmask[k*REG_W +: REG_W] = (wr_acc && in_prio && prio_idx == 5'(k)) ? be_mask : '0;
    assign prio_wdata[k*REG_W +: REG_W] = wdata;
  end

  // Set wins over a software clear in the same cycle; dead vectors stay zero
  wire [FLAG_BITS-1:0] flag_d =
    (((flag_q & ~flag_wmask) | (flag_wdata & flag_wmask)) | set_vec) & SRC_LIVE;
  wire [FLAG_BITS-1:0] enable_d =
    ((enable_q & ~en_wmask) | (flag_wdata & en_wmask)) & SRC_LIVE;
  wire [PRIO_BITS-1:0] prio_d =
    ((prio_q & ~prio_wmask) | (prio_wdata & prio_wmask)) & PRIO_LIVE;

  // Flag, enable and priority banks
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      flag_q <= '0;
      enable_q <= '0;
      prio_q <= '0;
    end
    else
    begin
      flag_q <= flag_d;
      enable_q <= enable_d;
      prio_q <= prio_d;
    end
  end

  // Global control registers; trap status flags are also set by the core
  wire wr_ctrl_a = wr_acc && addr == OFS_CTRL_A;
  wire wr_ctrl_b = wr_acc && addr == OFS_CTRL_B;
  wire [15:0] ctrl_a_wm = wr_ctrl_a ? (be_mask & CTRLA_RW_MASK) : '0;
  wire [15:0] ctrl_b_wm = wr_ctrl_b ? (be_mask & CTRLB_RW_MASK) : '0;
  wire [15:0] trap_set = 16'(trap_event_i) << CTRLA_TRAP_LSB;
  wire [15:0] ctrl_a_d = ((ctrl_a_q & ~ctrl_a_wm) | (wdata & ctrl_a_wm)) | trap_set;
  wire [15:0] ctrl_b_d = (ctrl_b_q & ~ctrl_b_wm) | (wdata & ctrl_b_wm);

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ctrl_a_q <= '0;
      ctrl_b_q <= '0;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // CPU level bits: core entry and return take precedence over software
  wire wr_cpu_status = wr_acc && addr == OFS_CPU_STATUS && avm_i.byteenable[0];
  wire wr_core_ctrl = wr_acc && addr == OFS_CORE_CTRL && avm_i.byteenable[0];
  wire take = cpu_ack_i & irq_q;
  logic [PRI_W-1:0] cpu_pri_d;
  always_comb
  begin
    cpu_pri_d = cpu_pri_q;
    if (take)
      cpu_pri_d = lvl_q[PRI_W-1:0];
    else if (cpu_ret_i)
      cpu_pri_d = cpu_ret_level_i[PRI_W-1:0];
    else if (wr_cpu_status && !nest_off)
      cpu_pri_d = wdata[CPU_PRI_LSB +: PRI_W];
  end

  // Top level bit: software may only clear it; traps and returns to a top level set it
  wire top_set = trap_entry_i | (cpu_ret_i & cpu_ret_level_i[LVL_W-1]);
  wire top_clr = (wr_core_ctrl & ~wdata[CORE_TOP_BIT]) | (cpu_ret_i & ~cpu_ret_level_i[LVL_W-1]);
  wire cpu_top_d = top_set | (cpu_top_q & ~top_clr);

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      cpu_pri_q <= '0;
      cpu_top_q <= 1'b0;
    end
    else
    begin
      cpu_pri_q <= cpu_pri_d;
      cpu_top_q <= cpu_top_d;
    end
  end

  // Handler nesting depth, saturating at both ends
  // Saturation keeps a stray return from wrapping the count to full
  wire depth_full = &depth_q;
  wire depth_zero = depth_q == '0;
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      depth_q <= '0;
    else if (take && !cpu_ret_i && !depth_full)
      depth_q <= depth_q + 1'b1;
    else if (cpu_ret_i && !take && !depth_zero)
      depth_q <= depth_q - 1'b1;
  end

  // Arbitration over enabled pending sources with nonzero priority
  logic [NUM_USER-1:0] active;
  logic [NUM_USER*PRI_W-1:0] prio_pk;
  for (genvar j = 0; j < NUM_USER; j++)
  begin : g_src
    assign prio_pk[j*PRI_W +: PRI_W] = prio_q[j*PRIO_STRIDE +: PRI_W];
    assign active[j] = flag_q[j] & enable_q[j] & (|prio_pk[j*PRI_W +: PRI_W]);
  end

  logic win_found;
  logic [VEC_W-1:0] win_idx;
  logic [PRI_W-1:0] win_pri;

  vpic_arbiter #(
    .N(NUM_USER),
    .PW(PRI_W),
    .IW(VEC_W)
  ) u_arbiter (
    .active_i(active),
    .prio_i(prio_pk),
    .found_o(win_found),
    .index_o(win_idx),
    .prio_o(win_pri)
  );

  // A level of 7 or a set top bit leaves no 3-bit priority above it
  wire [LVL_W-1:0] win_level = {1'b0, win_pri};
  wire [VEC_W-1:0] win_vec = win_idx + VEC_W'(FIRST_USER_VEC);
  wire above = win_level > cpu_level;
  wire nest_block = nest_off && !depth_zero;
  wire hit = win_found && above && !nest_block && !take;
  wire [23:0] table_sel = alt_sel ? ALT_TABLE_OFS : 24'h00_0000;
  wire [23:0] win_addr = TABLE_BASE + table_sel + 24'({win_vec, 1'b0});

  // Presented request and latched vector status
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_q <= 1'b0;
      vec_q <= '0;
      lvl_q <= '0;
      addr_q <= '0;
    end
    else
    begin
      irq_q <= hit;
      if (hit)
      begin
        vec_q <= win_vec;
        lvl_q <= win_level;
        addr_q <= win_addr;
      end
    end
  end

  // Read selection; unmapped addresses read as zero
  wire [15:0] cpu_status_rd = 16'(cpu_pri_q) << CPU_PRI_LSB;
  wire [15:0] core_ctrl_rd = 16'(cpu_top_q) << CORE_TOP_BIT;
  wire [15:0] pend_rd = (16'(lvl_q) << PEND_LVL_LSB) | 16'(vec_q);
  wire [15:0] rd_mux =
    (addr == OFS_CTRL_A) ? ctrl_a_q :
    (addr == OFS_CTRL_B) ? ctrl_b_q :
    (addr == OFS_CPU_STATUS) ? cpu_status_rd :
    (addr == OFS_CORE_CTRL) ? core_ctrl_rd :
    (addr == OFS_PEND_STATUS) ? pend_rd :
    in_flag ? flag_q[flag_idx*REG_W +: REG_W] :
    in_en ? enable_q[en_idx*REG_W +: REG_W] :
    in_prio ? prio_q[prio_idx*REG_W +: REG_W] :
    16'h0000;

  // Read data is captured in the wait cycle so it stands at the accepting edge
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      phase_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      phase_q <= bus_req & ~phase_q;
      if (bus_req && !phase_q)
        rdata_q <= 32'(rd_mux);
    end
  end

  assign avm_o.waitrequest = bus_req & ~phase_q;
  assign avm_o.readdata = rdata_q;
  assign cpu_o.irq = irq_q;
  assign cpu_o.vector_num = vec_q;
  assign cpu_o.level = lvl_q;
  assign cpu_o.vector_addr = addr_q;

  // Checks on the controller's own outputs and state
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  a_irq_above_level: assert property (irq_q |-> lvl_q > $past(cpu_level))
    else $error("request presented without exceeding CPU level");
  a_top_blocks_user: assert property (cpu_top_q |=> !irq_q)
    else $error("request presented while top level bit set");
  a_level7_blocks: assert property (cpu_pri_q == 3'h7 |=> !irq_q)
    else $error("request presented at CPU level seven");
  a_zero_prio_idle: assert property (irq_q |-> lvl_q != '0)
    else $error("priority zero source presented");
  a_latch_vector: assert property (hit |=> irq_q && vec_q == $past(win_vec)
    && lvl_q == $past(win_level))
    else $error("vector status not latched from winner");
  a_flag_sticky: assert property (flag_wmask == '0
    |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("pending flag cleared without software write");
  a_level_locked: assert property (nest_off && !take && !cpu_ret_i
    |=> cpu_pri_q == $past(cpu_pri_q))
    else $error("CPU level changed by software while nesting disabled");
  a_top_clear_only: assert property (!trap_entry_i && !cpu_ret_i |=> !$rose(cpu_top_q))
    else $error("top level bit set without trap or return");
  a_nest_blocked: assert property (nest_off && depth_q != '0 |=> !irq_q)
    else $error("preemption while nesting disabled");
  a_table_select: assert property (irq_q
    |-> addr_q[8] == ($past(alt_sel) ^ (vec_q > 7'h7D)))
    else $error("vector address from wrong table");

  // Core handshake, return and trap bookkeeping
  a_take_sets_level: assert property (take
    |=> cpu_pri_q == $past(lvl_q[PRI_W-1:0]))
    else $error("CPU level not raised to the taken level");
  a_ret_restores: assert property (cpu_ret_i && !take
    |=> cpu_pri_q == $past(cpu_ret_level_i[PRI_W-1:0]))
    else $error("CPU level not restored on return");
  a_winner_live: assert property (irq_q
    |-> $past(flag_q[win_idx] && enable_q[win_idx]))
    else $error("request presented for a source not pending and enabled");
  a_trap_sets_top: assert property (trap_entry_i |=> cpu_top_q)
    else $error("top level bit not set on trap entry");
  a_trap_flag_set: assert property (|trap_event_i
    |=> (ctrl_a_q & $past(trap_set)) == $past(trap_set))
    else $error("trap status flag lost its set");

  c_take_irq: cover property (irq_q ##1 take);
  c_nested_take: cover property (take && depth_q != '0);
  c_alt_table: cover property (irq_q && alt_sel);
  c_set_clear_race: cover property (|(flag_wmask & set_vec));
  c_pin_event: cover property (|ext_evt);
endmodule

/* verilog/vpic_pkg.sv */
// Constants, types and helper functions for the vectored priority interrupt controller
package vpic_pkg;

  localparam int unsigned VEC_W = 7;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned PRI_W = 3;
  localparam int unsigned REG_W = 16;
  localparam int unsigned FIRST_USER_VEC = 8;
  localparam int unsigned LAST_VEC = 126;
  localparam int unsigned NUM_USER = LAST_VEC - FIRST_USER_VEC + 1;
  localparam int unsigned FLAG_REGS = 8;
  localparam int unsigned PRIO_REGS = 30;
  localparam int unsigned FLAG_BITS = FLAG_REGS * REG_W;
  localparam int unsigned PRIO_BITS = PRIO_REGS * REG_W;
  localparam int unsigned PRIO_STRIDE = 4;
  localparam int unsigned EXT_PINS = 3;

  // Source vector numbers
  localparam int unsigned VEC_EXT0 = 8;
  localparam int unsigned VEC_EXT1 = 28;
  localparam int unsigned VEC_EXT2 = 37;
  localparam int unsigned VEC_PAR_PORT = 53;
  localparam int unsigned VEC_DMA4 = 54;
  localparam int unsigned VEC_PWM1_PERIOD = 65;
  localparam int unsigned VEC_POS_CMP1 = 66;
  localparam int unsigned VEC_DMA5 = 69;
  localparam int unsigned VEC_RTC = 70;
  localparam int unsigned VEC_PWM1_FAULT = 71;
  localparam int unsigned VEC_UART1_ERR = 73;
  localparam int unsigned VEC_UART2_ERR = 74;
  localparam int unsigned VEC_CRC = 75;
  localparam int unsigned VEC_DMA6 = 76;
  localparam int unsigned VEC_DMA7 = 77;
  localparam int unsigned VEC_CAN_TX = 78;
  localparam int unsigned VEC_PWM2_PERIOD = 81;
  localparam int unsigned VEC_PWM2_FAULT = 82;
  localparam int unsigned VEC_POS_CMP2 = 83;
  localparam int unsigned VEC_DAC_RIGHT = 86;
  localparam int unsigned VEC_DAC_LEFT = 87;
  localparam int unsigned VEC_RSV_LO = 88;

  // Vector table placement
  localparam logic [23:0] TABLE_BASE = 24'h00_0004;
  localparam logic [23:0] ALT_TABLE_OFS = 24'h00_0100;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CPU_STATUS = 8'h08;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h0C;
  localparam logic [7:0] OFS_PEND_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLAG0 = 8'h40;
  localparam logic [7:0] OFS_ENABLE0 = 8'h60;
  localparam logic [7:0] OFS_PRIO0 = 8'h80;

  // Field positions and masks
  localparam int unsigned CTRLA_NEST_BIT = 15;
  localparam int unsigned CTRLA_TRAP_LSB = 1;
  localparam int unsigned TRAP_FLAGS = 14;
  localparam logic [15:0] CTRLA_RW_MASK = 16'hFFFE;
  localparam int unsigned CTRLB_ALT_BIT = 15;
  localparam logic [15:0] CTRLB_RW_MASK = 16'h8007;
  localparam int unsigned CPU_PRI_LSB = 5;
  localparam int unsigned CORE_TOP_BIT = 3;
  localparam int unsigned PEND_LVL_LSB = 8;
  localparam int unsigned DEPTH_W = 4;

  // Bus and CPU carriers
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } vpic_avm_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } vpic_avm_rsp_t;

  typedef struct packed {
    logic irq;
    logic [VEC_W-1:0] vector_num;
    logic [LVL_W-1:0] level;
    logic [23:0] vector_addr;
  } vpic_cpu_req_t;

  // Vectors with no source behind them keep their flag, enable and priority at zero
  function automatic logic vec_has_source(input int unsigned v);
    return !(v == 23 || v == 29 || (v >= 45 && v <= 52) || (v >= 55 && v <= 64) ||
      v == 67 || v == 68 || v == 72 || v == 79 || v == 80 || v == 84 || v == 85 ||
      v >= VEC_RSV_LO);
  endfunction

  function automatic logic [FLAG_BITS-1:0] src_live_mask();
    logic [FLAG_BITS-1:0] m;
    m = '0;
    for (int j = 0; j < NUM_USER; j++) m[j] = vec_has_source(FIRST_USER_VEC + j);
    return m;
  endfunction

  function automatic logic [PRIO_BITS-1:0] prio_live_mask();
    logic [PRIO_BITS-1:0] m;
    m = '0;
    for (int j = 0; j < NUM_USER; j++)
      m[j*PRIO_STRIDE +: PRI_W] = {PRI_W{vec_has_source(FIRST_USER_VEC + j)}};
    return m;
  endfunction

  localparam logic [FLAG_BITS-1:0] SRC_LIVE = src_live_mask();
  localparam logic [PRIO_BITS-1:0] PRIO_LIVE = prio_live_mask();

endpackage

/* verilog/vpic_pin_sync.sv */
// Three-stage pin synchroniser with selectable edge detection
module vpic_pin_sync #(
  parameter int unsigned W = 3
) (
  input wire logic clock_i,            // System clock
  input wire logic reset_i,            // Synchronous reset, active high
  input wire logic [W-1:0] pin_i,      // Asynchronous request pins
  input wire logic [W-1:0] fall_sel_i, // 1 selects falling edge
  output logic [W-1:0] edge_o          // One-cycle edge pulse
);
  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;
  logic [W-1:0] stable_q;
  logic [W-1:0] edge_q;
  wire [W-1:0] agree = ~(ff2_q ^ ff3_q);
  wire [W-1:0] rise = agree & ff3_q & ~stable_q;
  wire [W-1:0] fall = agree & ~ff3_q & stable_q;

  // A change only counts once stages two and three agree
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      stable_q <= '0;
      edge_q <= '0;
    end
    else
    begin
      ff1_q <= pin_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      stable_q <= (stable_q & ~agree) | (ff3_q & agree);
      edge_q <= (rise & ~fall_sel_i) | (fall & fall_sel_i);
    end
  end

  assign edge_o = edge_q;
endmodule

/* verilog/vpic_arbiter.sv */
// Highest-priority search over enabled pending sources
module vpic_arbiter #(
  parameter int unsigned N = 119,
  parameter int unsigned PW = 3,
  parameter int unsigned IW = 7
) (
  input wire logic [N-1:0] active_i,   // Pending, enabled, nonzero priority
  input wire logic [N*PW-1:0] prio_i,  // Packed priorities, source 0 lowest
  output logic found_o,                // Some source is active
  output logic [IW-1:0] index_o,       // Winning source index
  output logic [PW-1:0] prio_o         // Winning priority
);
  // Scanning downward with >= lets the lower index win a tie
  always_comb
  begin
    found_o = 1'b0;
    index_o = '0;
    prio_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (active_i[i] && prio_i[i*PW +: PW] >= prio_o)
      begin
        found_o = 1'b1;
        index_o = IW'(i);
        prio_o = prio_i[i*PW +: PW];
      end
    end
  end
endmodule

/* testbench/vpic_cpu_model.sv */
// Behavioural core that takes vectored requests and returns after a fixed handler time
module vpic_cpu_model #(
  parameter int RUN = 30
) (
  input wire logic clock_i,                  // System clock
  input wire logic reset_i,                  // Synchronous reset
  input wire vpic_pkg::vpic_cpu_req_t cpu_i, // Request from controller
  input wire logic [3:0] ack_dly_i,          // Cycles before taking a request
  output logic ack_o,                        // Takes the presented request
  output logic ret_o,                        // Handler return
  output logic [3:0] ret_level_o             // Level restored on return
);
  timeunit 1ns;
  timeprecision 1ps;
  import vpic_pkg::*;
  logic busy_q;
  int wait_q;
  int run_q;
  // Handlers are only entered from level 0 here, so a return restores 0
  assign ret_level_o = 4'h0;
  // Ack only while the request stands, one handler at a time
  always @(posedge clock_i)
  begin
    ack_o <= 1'b0;
    ret_o <= 1'b0;
    if (reset_i)
    begin
      busy_q <= 1'b0;
      wait_q <= 0;
      run_q <= 0;
    end
    else if (busy_q)
    begin
      run_q <= run_q + 1;
      if (run_q == RUN)
      begin
        busy_q <= 1'b0;
        ret_o <= 1'b1;
      end
    end
    else if (cpu_i.irq === 1'b1)
    begin
      wait_q <= wait_q + 1;
      if (wait_q >= int'(ack_dly_i))
      begin
        ack_o <= 1'b1;
        busy_q <= 1'b1;
        wait_q <= 0;
        run_q <= 0;
      end
    end
  end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the vectored priority interrupt controller
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vpic_pkg::*;
  logic clock_i;
  logic reset_i;
  vpic_avm_req_t avm_i;
  vpic_avm_rsp_t avm_o;
  logic [NUM_USER-1:0] src_req_i;
  logic [EXT_PINS-1:0] ext_pin_i;
  logic [TRAP_FLAGS-1:0] trap_event_i;
  logic trap_entry_i;
  logic cpu_ack_i;
  logic cpu_ret_i;
  logic [LVL_W-1:0] cpu_ret_level_i;
  vpic_cpu_req_t cpu_o;
  logic [3:0] ack_dly;
  logic [31:0] rnd;
  logic [2:0] pri;
  logic [15:0] exp_rd[$];
  logic [34:0] exp_vec[$];
  logic [15:0] rd_note;
  logic [34:0] vec_note;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  vpic_ctrl i_vpic_ctrl (.clock_i(clock_i), .reset_i(reset_i), .avm_i(avm_i), .avm_o(avm_o),
    .src_req_i(src_req_i), .ext_pin_i(ext_pin_i), .trap_event_i(trap_event_i),
    .trap_entry_i(trap_entry_i), .cpu_ack_i(cpu_ack_i), .cpu_ret_i(cpu_ret_i),
    .cpu_ret_level_i(cpu_ret_level_i), .cpu_o(cpu_o));
  vpic_cpu_model i_vpic_cpu_model (.clock_i(clock_i), .reset_i(reset_i), .cpu_i(cpu_o),
    .ack_dly_i(ack_dly), .ack_o(cpu_ack_i), .ret_o(cpu_ret_i), .ret_level_o(cpu_ret_level_i));

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end

  // Results are compared against the oldest note when they appear
  always @(posedge clock_i)
  begin
    if (avm_i.read && avm_o.waitrequest === 1'b0)
    begin
      rd_note = (exp_rd.size() > 0) ? exp_rd.pop_front() : 'x;
      `CHK("readdata", rd_note, avm_o.readdata[15:0])
    end
    if (cpu_ack_i && cpu_o.irq === 1'b1)
    begin
      vec_note = (exp_vec.size() > 0) ? exp_vec.pop_front() : 'x;
      `CHK("vector", vec_note, {cpu_o.vector_addr, cpu_o.vector_num, cpu_o.level})
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Request held until the edge that sees waitrequest low, released right after
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    avm_i <= '{address: a, read: !wr, write: wr, writedata: {16'h0000, d}, byteenable: 4'h3};
    do @(posedge clock_i); while (avm_o.waitrequest !== 1'b0);
    avm_i.read <= 1'b0;
    avm_i.write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  task automatic pulse(input logic [NUM_USER-1:0] m);
    src_req_i <= m;
    @(posedge clock_i);
    src_req_i <= '0;
  endtask

  task automatic drain(input int left);
    while (exp_vec.size() > left) @(posedge clock_i);
  endtask

  initial
  begin
    reset_i = 1'b1;
    avm_i = '0;
    src_req_i = '0;
    ext_pin_i = '0;
    trap_event_i = '0;
    trap_entry_i = 1'b0;
    ack_dly = 4'h0;
    rnd = 32'h0000_003B;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    // Reset values, unmapped space, trap flag, top level bit clear-only
    rd(OFS_CTRL_A, 16'h0000);
    rd(OFS_CPU_STATUS, 16'h0000);
    rd(8'hF8, 16'h0000);
    bus(1'b1, OFS_CORE_CTRL, 16'h0008);
    rd(OFS_CORE_CTRL, 16'h0000);
    trap_event_i <= 14'h0001;
    trap_entry_i <= 1'b1;
    @(posedge clock_i);
    trap_event_i <= '0;
    trap_entry_i <= 1'b0;
    rd(OFS_CTRL_A, 16'h0002);
    rd(OFS_CORE_CTRL, 16'h0008);
    bus(1'b1, OFS_CORE_CTRL, 16'h0000);
    bus(1'b1, OFS_CTRL_A, 16'h0000);
    rd(OFS_CORE_CTRL, 16'h0000);
    // Flag word of vectors 72..87 keeps only the sourced bits
    rnd = xs(rnd);
    bus(1'b1, 8'h50, rnd[15:0]);
    rd(8'h50, rnd[15:0] & 16'hCE7E);
    bus(1'b1, 8'h50, 16'h0000);
    $display("test registers done");
    // Vector 11 at a random level, prompt core
    rnd = xs(rnd);
    pri = 3'(rnd % 6 + 1);
    bus(1'b1, OFS_PRIO0, {1'b0, pri, 12'h000});
    bus(1'b1, OFS_ENABLE0, 16'h0008);
    exp_vec.push_back({24'h00_001A, 7'd11, 1'b0, pri});
    pulse(119'h8);
    drain(0);
    rd(OFS_PEND_STATUS, {4'h0, 1'b0, pri, 8'h0B});
    rd(OFS_CPU_STATUS, {8'h00, pri, 5'h00});
    rd(OFS_FLAG0, 16'h0008);
    bus(1'b1, OFS_FLAG0, 16'h0000);
    repeat (40) @(posedge clock_i);
    $display("test single done");
    // Level 7 blocks; priority 0 and disabled sources never reach the core
    bus(1'b1, OFS_PRIO0, 16'h6500);
    bus(1'b1, OFS_ENABLE0, 16'h000A);
    bus(1'b1, OFS_CPU_STATUS, 16'h00E0);
    pulse(119'hE);
    repeat (10) @(posedge clock_i);
    `CHK("irq", 1'b0, cpu_o.irq)
    exp_vec.push_back({24'h00_001A, 7'd11, 4'h6});
    bus(1'b1, OFS_CPU_STATUS, 16'h0000);
    drain(0);
    bus(1'b1, OFS_FLAG0, 16'h0006);
    repeat (40) @(posedge clock_i);
    `CHK("irq", 1'b0, cpu_o.irq)
    bus(1'b1, OFS_FLAG0, 16'h0000);
    bus(1'b1, OFS_ENABLE0, 16'h0000);
    $display("test blocking done");
    // Equal priority tie through the alternate table, slow core
    ack_dly <= 4'h5;
    bus(1'b1, OFS_CTRL_B, 16'h8000);
    bus(1'b1, 8'hB8, 16'h0330);
    bus(1'b1, 8'h6C, 16'h0600);
    exp_vec.push_back({24'h00_0186, 7'd65, 4'h3});
    exp_vec.push_back({24'h00_0188, 7'd66, 4'h3});
    pulse(119'h3 << 57);
    drain(1);
    bus(1'b1, 8'h4C, 16'h0400);
    drain(0);
    bus(1'b1, 8'h4C, 16'h0000);
    bus(1'b1, 8'h6C, 16'h0000);
    bus(1'b1, OFS_CTRL_B, 16'h0000);
    repeat (40) @(posedge clock_i);
    $display("test tie done");
    // Nesting disable freezes the level bits against software
    bus(1'b1, OFS_CTRL_A, 16'h8000);
    bus(1'b1, OFS_CPU_STATUS, 16'h00A0);
    rd(OFS_CPU_STATUS, 16'h0000);
    // A higher source during a running handler must wait
    bus(1'b1, OFS_PRIO0, 16'h2600);
    bus(1'b1, OFS_ENABLE0, 16'h000C);
    exp_vec.push_back({24'h00_001A, 7'd11, 4'h2});
    pulse(119'h8);
    drain(0);
    pulse(119'h4);
    repeat (10) @(posedge clock_i);
    `CHK("irq", 1'b0, cpu_o.irq)
    bus(1'b1, OFS_FLAG0, 16'h0000);
    bus(1'b1, OFS_ENABLE0, 16'h0000);
    bus(1'b1, OFS_CTRL_A, 16'h0000);
    repeat (40) @(posedge clock_i);
    $display("test nesting done");
    // Pin 0 on falling edge: the rise is ignored, the fall sets vector 8
    bus(1'b1, OFS_CTRL_B, 16'h0001);
    bus(1'b1, OFS_PRIO0, 16'h0004);
    bus(1'b1, OFS_ENABLE0, 16'h0001);
    ext_pin_i <= 3'b001;
    repeat (10) @(posedge clock_i);
    `CHK("irq", 1'b0, cpu_o.irq)
    exp_vec.push_back({24'h00_0014, 7'd8, 4'h4});
    ext_pin_i <= 3'b000;
    drain(0);
    bus(1'b1, OFS_FLAG0, 16'h0000);
    bus(1'b1, OFS_ENABLE0, 16'h0000);
    bus(1'b1, OFS_CTRL_B, 16'h0000);
    $display("test pins done");
    conclude();
  end
endmodule
